// ==== logic/tai_pkg.sv ====
// Summary of operation
// [RULE_01] remote2 code low bits at bits 7:6
// [RULE_02] remote2 code msb from separate register
// [RULE_03] remote2 code sets adjustment spacing
// [RULE_04] delay counted in monitoring cycles, eight per second
// [RULE_05] decrease interval 8 shl code cycles
// [RULE_06] increase interval twice decrease interval
// [RULE_07] local code at bits 5:3
// [RULE_08] remote1 code at bits 2:0
// [RULE_09] restart count after each adjustment
`default_nettype none
package tai_pkg;
  localparam int CODE_W = 3;
  localparam int CHANNELS = 3;
  localparam int CNT_W = 12;
  localparam int REMOTE1_LSB = 0;
  localparam int LOCAL_LSB = 3;
  localparam int REMOTE2_LSB = 6;
  localparam int REMOTE2_MSB_POS = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DYN_RESET = 8'h00;
  localparam int MON_CYCLES_PER_SEC = 8;
  localparam logic [CNT_W-1:0] DEC_BASE_CYCLES = 12'h008;
  localparam logic [CNT_W-1:0] INC_BASE_CYCLES = 12'h010;

  typedef struct packed {
    logic lower;
    logic raise;
  } tai_req_t;

  typedef struct packed {
    logic lowerOk;
    logic raiseOk;
  } tai_grant_t;

  function automatic logic [CNT_W-1:0] tai_interval(input logic [CODE_W-1:0] code, input logic inc);
    logic [CNT_W-1:0] base;
    base = inc ? INC_BASE_CYCLES : DEC_BASE_CYCLES;
    return CNT_W'(base << code);
  endfunction
endpackage
`default_nettype wire

// ==== logic/tai_channel_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tai_channel_timer
  import tai_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // timing
  input wire logic monTick,
  input wire logic [CODE_W-1:0] code,
  // adjustment handshake
  input wire tai_req_t req,
  output tai_grant_t grant,
  output logic lowerDone,
  output logic raiseDone
);
  logic [CNT_W-1:0] lowerCnt;
  logic [CNT_W-1:0] raiseCnt;

  // counters saturate at the interval so a later code change takes effect at once
  assign grant.lowerOk = lowerCnt >= tai_interval(code, 1'b0); // [RULE_05]
  assign grant.raiseOk = raiseCnt >= tai_interval(code, 1'b1); // [RULE_06]

  always_ff @(posedge clock)
  begin
    if (rst)
      lowerCnt <= '0;
    else if (req.lower && grant.lowerOk)
      lowerCnt <= '0; // [RULE_09]
    else if (monTick && !grant.lowerOk)
      lowerCnt <= CNT_W'(lowerCnt + 1'b1); // [RULE_04]
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      raiseCnt <= '0;
    else if (req.raise && grant.raiseOk)
      raiseCnt <= '0; // [RULE_09]
    else if (monTick && !grant.raiseOk)
      raiseCnt <= CNT_W'(raiseCnt + 1'b1); // [RULE_04]
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lowerDone <= 1'b0;
      raiseDone <= 1'b0;
    end
    else
    begin
      lowerDone <= req.lower && grant.lowerOk;
      raiseDone <= req.raise && grant.raiseOk && !(req.lower && grant.lowerOk);
    end
  end

  lower_wait_a: assert property (@(posedge clock) disable iff (rst)
    (req.lower && grant.lowerOk) |=> !grant.lowerOk) else $error("lower allowed twice"); // [RULE_09]
  raise_wait_a: assert property (@(posedge clock) disable iff (rst)
    (req.raise && grant.raiseOk && !(req.lower && grant.lowerOk)) |=> !grant.raiseOk)
    else $error("raise allowed twice"); // [RULE_09]
  // with equal counts and lower not yet granted, raise is short of its longer interval, so raise must not lead lower
  raise_longer_a: assert property (@(posedge clock) disable iff (rst)
    (raiseCnt == lowerCnt) && !grant.lowerOk |-> !grant.raiseOk) else $error("raise before lower interval"); // [RULE_06]
  lower_count_a: assert property (@(posedge clock) disable iff (rst)
    (!grant.lowerOk && !monTick) |=> $stable(lowerCnt) || $past(req.lower)) else $error("count moved without tick"); // [RULE_04]
endmodule // tai_channel_timer
`default_nettype wire

// ==== logic/tai_interval_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tai_interval_top
  import tai_pkg::*;
#(
  parameter int CHAN = CHANNELS
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register writes
  input wire logic ctrlWrite,
  input wire logic [7:0] ctrlWdata,
  input wire logic dynWrite,
  input wire logic [7:0] dynWdata,
  // register read back
  output logic [7:0] ctrlRdata,
  output logic [7:0] dynRdata,
  // monitoring loop
  input wire logic monTick,
  input wire tai_req_t [CHAN-1:0] adjReq,
  output tai_grant_t [CHAN-1:0] adjGrant,
  output logic [CHAN-1:0] lowerDone,
  output logic [CHAN-1:0] raiseDone,
  // decoded codes: remote1, local, remote2
  output logic [CODE_W-1:0] remote1_interval_code,
  output logic [CODE_W-1:0] local_interval_code,
  output logic [CODE_W-1:0] remote2_interval_code
);
  // the code decode below serves exactly remote1, local and remote2
  if (CHAN != CHANNELS)
  begin : g_bad_chan
    $error("three channels only");
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrlRdata <= CTRL_RESET;
    else if (ctrlWrite)
      ctrlRdata <= ctrlWdata; // [RULE_01] [RULE_07] [RULE_08]
  end

  // other bits of this register belong to neighbouring logic; stored only
  always_ff @(posedge clock)
  begin
    if (rst)
      dynRdata <= DYN_RESET;
    else if (dynWrite)
      dynRdata <= dynWdata; // [RULE_02]
  end

  ////////////////////////////////////////////////////////////////
  assign remote1_interval_code = ctrlRdata[REMOTE1_LSB +: CODE_W]; // [RULE_08]
  assign local_interval_code = ctrlRdata[LOCAL_LSB +: CODE_W]; // [RULE_07]
  assign remote2_interval_code = {dynRdata[REMOTE2_MSB_POS], ctrlRdata[REMOTE2_LSB +: 2]}; // [RULE_01] [RULE_02]

  logic [CODE_W-1:0] codes [CHAN];
  assign codes[0] = remote1_interval_code;
  assign codes[1] = local_interval_code;
  assign codes[2] = remote2_interval_code; // [RULE_03]

  for (genvar i = 0; i < CHAN; i++)
  begin : g_chan
    tai_channel_timer u_timer (
      .clock(clock),
      .rst(rst),
      .monTick(monTick),
      .code(codes[i]),
      .req(adjReq[i]),
      .grant(adjGrant[i]),
      .lowerDone(lowerDone[i]),
      .raiseDone(raiseDone[i])
    );
  end

  remote2_code_a: assert property (@(posedge clock) disable iff (rst)
    $rose(dynWrite) && dynWdata[0] |=> remote2_interval_code[2]) else $error("remote2 msb not taken"); // [RULE_02]
  remote2_low_a: assert property (@(posedge clock) disable iff (rst)
    ctrlWrite |=> remote2_interval_code[1:0] == $past(ctrlWdata[7:6])) else $error("remote2 low bits wrong"); // [RULE_01]
  local_code_a: assert property (@(posedge clock) disable iff (rst)
    ctrlWrite |=> local_interval_code == $past(ctrlWdata[5:3])) else $error("local code wrong"); // [RULE_07]
  remote1_code_a: assert property (@(posedge clock) disable iff (rst)
    ctrlWrite |=> remote1_interval_code == $past(ctrlWdata[2:0])) else $error("remote1 code wrong"); // [RULE_08]
  reset_grant_a: assert property (@(posedge clock)
    rst |=> !adjGrant[2].lowerOk && !adjGrant[2].raiseOk) else $error("grant after reset"); // [RULE_03]
  lower_cov: cover property (@(posedge clock) disable iff (rst) lowerDone[2]);
  raise_cov: cover property (@(posedge clock) disable iff (rst) raiseDone[0]);
  code_cov: cover property (@(posedge clock) disable iff (rst) remote2_interval_code == 3'h7);
  both_cov: cover property (@(posedge clock) disable iff (rst)
    adjReq[0].lower && adjGrant[0].lowerOk && adjReq[0].raise && adjGrant[0].raiseOk);

  ////////////////////////////////////////////////////////////////
  // registers only move on their own write strobe
  ctrl_hold_a: assert property (@(posedge clock) disable iff (rst)
    !ctrlWrite |=> $stable(ctrlRdata)) else $error("control register moved"); // [RULE_01]
  dyn_hold_a: assert property (@(posedge clock) disable iff (rst)
    !dynWrite |=> $stable(dynRdata)) else $error("dynamic register moved"); // [RULE_02]

  ////////////////////////////////////////////////////////////////
  // per channel handshake checks
  for (genvar k = 0; k < CHAN; k++)
  begin : g_chk
    lower_done_a: assert property (@(posedge clock) disable iff (rst)
      (adjReq[k].lower && adjGrant[k].lowerOk) |=> lowerDone[k]) else $error("lower not acknowledged"); // [RULE_09]
    lower_refuse_a: assert property (@(posedge clock) disable iff (rst)
      !(adjReq[k].lower && adjGrant[k].lowerOk) |=> !lowerDone[k]) else $error("lower acknowledged early"); // [RULE_09]
    raise_refuse_a: assert property (@(posedge clock) disable iff (rst)
      !(adjReq[k].raise && adjGrant[k].raiseOk) |=> !raiseDone[k]) else $error("raise acknowledged early"); // [RULE_09]
    both_taken_a: assert property (@(posedge clock) disable iff (rst)
      (adjReq[k].lower && adjGrant[k].lowerOk && adjReq[k].raise && adjGrant[k].raiseOk)
      |=> lowerDone[k] && !raiseDone[k] && !adjGrant[k].raiseOk) else $error("double adjustment wrong"); // [RULE_09]
    lower_pulse_a: assert property (@(posedge clock) disable iff (rst)
      lowerDone[k] |=> !lowerDone[k]) else $error("lower done too long"); // [RULE_09]
    raise_pulse_a: assert property (@(posedge clock) disable iff (rst)
      raiseDone[k] |=> !raiseDone[k]) else $error("raise done too long"); // [RULE_09]
    // a write may lengthen the interval and withdraw a grant, so it is excluded
    lower_keep_a: assert property (@(posedge clock) disable iff (rst)
      adjGrant[k].lowerOk && !adjReq[k].lower && !ctrlWrite && !dynWrite |=> adjGrant[k].lowerOk)
      else $error("lower grant lost"); // [RULE_05]
    raise_keep_a: assert property (@(posedge clock) disable iff (rst)
      adjGrant[k].raiseOk && !adjReq[k].raise && !ctrlWrite && !dynWrite |=> adjGrant[k].raiseOk)
      else $error("raise grant lost"); // [RULE_06]
  end
endmodule // tai_interval_top
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tai_pkg::*;
  logic clock, rst, ctrlWrite, dynWrite, monTick;
  logic [7:0] ctrlWdata, dynWdata, ctrlRdata, dynRdata;
  tai_req_t [2:0] adjReq;
  tai_grant_t [2:0] adjGrant;
  logic [2:0] lowerDone, raiseDone;
  logic [CODE_W-1:0] r1Code, lcCode, r2Code;
  int n_errors = 0;
  int cmp_count = 0;
  tai_interval_top tai_interval_top_inst (.clock(clock), .rst(rst), .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata),
    .dynWrite(dynWrite), .dynWdata(dynWdata), .ctrlRdata(ctrlRdata), .dynRdata(dynRdata), .monTick(monTick),
    .adjReq(adjReq), .adjGrant(adjGrant), .lowerDone(lowerDone), .raiseDone(raiseDone),
    .remote1_interval_code(r1Code), .local_interval_code(lcCode), .remote2_interval_code(r2Code));
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge clock);
    {ctrlWrite, dynWrite, ctrlWdata, dynWdata} = {2'b11, c, d};
    @(negedge clock);
    {ctrlWrite, dynWrite} = 2'b00;
  endtask
  // one monitoring tick per two clocks, grants settled on return
  task tick(input int n);
    repeat (n)
    begin
      @(negedge clock) monTick = 1'b1;
      @(negedge clock) monTick = 1'b0;
    end
  endtask
  task take(input int ch, input logic up);
    if (up) adjReq[ch].raise = 1'b1; else adjReq[ch].lower = 1'b1;
    @(negedge clock);
    adjReq = '0;
    chk({lowerDone[ch], raiseDone[ch]}, up ? 8'h01 : 8'h02);
    chk(up ? adjGrant[ch].raiseOk : adjGrant[ch].lowerOk, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task sc_codes;
    chk(ctrlRdata, 8'h00);
    chk({adjGrant}, 8'h00);
    wr(8'hAC, 8'h01);
    chk(ctrlRdata, 8'hAC);
    chk(dynRdata, 8'h01);
    chk(r1Code, 8'h04);
    chk(lcCode, 8'h05);
    chk(r2Code, 8'h06);
  endtask
  // remote2 at 111 against remote1 and local at 000
  task sc_intervals;
    wr(8'hC0, 8'h01);
    chk(r2Code, 8'h07);
    tick(7);
    chk({adjGrant[1].lowerOk, adjGrant[0].lowerOk}, 8'h00);
    tick(1);
    chk({adjGrant[1].lowerOk, adjGrant[0].lowerOk}, 8'h03);
    chk(adjGrant[0].raiseOk, 8'h00);
    tick(8);
    chk(adjGrant[0].raiseOk, 8'h01);
    tick(1007);
    chk(adjGrant[2].lowerOk, 8'h00);
    tick(1);
    chk(adjGrant[2].lowerOk, 8'h01);
    tick(1023);
    chk(adjGrant[2].raiseOk, 8'h00);
    tick(1);
    chk(adjGrant[2].raiseOk, 8'h01);
  endtask
  task sc_restart;
    take(0, 1'b0);
    chk(adjGrant[0].raiseOk, 8'h01);
    tick(7);
    chk(adjGrant[0].lowerOk, 8'h00);
    tick(1);
    chk(adjGrant[0].lowerOk, 8'h01);
    take(1, 1'b1);
    tick(15);
    chk(adjGrant[1].raiseOk, 8'h00);
    tick(1);
    chk(adjGrant[1].raiseOk, 8'h01);
  endtask
  // both requested in one cycle, only lower acknowledged, then a refused request
  task sc_both;
    adjReq[0].lower = 1'b1;
    adjReq[0].raise = 1'b1;
    @(negedge clock);
    adjReq = '0;
    chk({lowerDone[0], raiseDone[0]}, 8'h02);
    chk({adjGrant[0]}, 8'h00);
    adjReq[0].lower = 1'b1;
    @(negedge clock);
    adjReq = '0;
    @(negedge clock);
    chk({lowerDone[0], raiseDone[0]}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, ctrlWrite, dynWrite, monTick, ctrlWdata, dynWdata} = {4'b1000, 16'h0000};
    adjReq = '0;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    sc_codes();
    sc_intervals();
    sc_restart();
    sc_both();
    close_out();
  end
endmodule // tb
`default_nettype wire
